//--- rtl/sdram_mode_regs.svh
/*
 * Constants for the mode word, burst and latency codes, and byte mask timing.
 * Assumes it is included by bare name in files that need the numbers.
 */
`ifndef SDRAM_MODE_REGS_SVH
`define SDRAM_MODE_REGS_SVH

// mode word field positions
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_ORDER_BIT 3
`define MODE_RL_LSB 4
`define MODE_RL_MSB 6
`define MODE_OP_LOW_BIT 7
`define MODE_OP_HIGH_BIT 8
`define MODE_WB_SINGLE_BIT 9
`define MODE_WORD_MSB 11
`define MODE_RESET_VALUE 12'h000

// burst length codes
`define BL_ONE 3'h0
`define BL_TWO 3'h1
`define BL_FOUR 3'h2
`define BL_EIGHT 3'h3
`define BL_PAGE 3'h7

// read latency codes
`define RL_TWO 3'h2
`define RL_THREE 3'h3

// column masks of one page, small and large modules
`define PAGE_MASK_SMALL 9'h0ff
`define PAGE_MASK_LARGE 9'h1ff

// address bit that selects auto precharge or all-bank precharge
`define PRECHARGE_SEL_BIT 10

// byte mask delays in clocks: writes at once, reads two clocks later
`define MASK_WRITE_DELAY 0
`define MASK_READ_DELAY 2

`endif

//--- rtl/sdram_mode_pkg.sv
/*
 * Types shared by the command decoder: decoded commands and burst states.
 * Assumes nothing of its surroundings.
 */
package sdram_mode_pkg;

    // decoded command from the strobe pins
    typedef enum logic [3:0] {
        cmd_inhibit,
        cmd_nop,
        cmd_active,
        cmd_read,
        cmd_write,
        cmd_term,
        cmd_precharge,
        cmd_refresh,
        cmd_load_mode
    } cmd_t;

    // burst sequencer state
    typedef enum logic [1:0] {
        burst_idle,
        burst_read,
        burst_write
    } burst_t;

endpackage : sdram_mode_pkg

//--- rtl/data_fifo.sv
/*
 * Synchronous FIFO with a registered output stage and valid/ready on both
 * sides. Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module data_fifo #(
    parameter int WIDTH = 83,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic wr;
    logic load;

    // full comes straight from the stored count, valid from the output stage flag
    assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = st_reg.ov;
    assign out_data = st_reg.od;

    // refill the output stage whenever it is empty or being taken
    always_comb begin
        st_next = st_reg;
        wr = in_valid && in_ready;
        load = (st_reg.cnt != '0) && (!st_reg.ov || out_ready);
        if (out_ready && st_reg.ov) begin
            st_next.ov = 1'b0;
        end
        if (load) begin
            st_next.od = st_reg.mem[st_reg.rp];
            st_next.ov = 1'b1;
            st_next.rp = st_reg.rp + 1'b1;
        end
        if (wr) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(wr) - (AW+1)'(load);
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : data_fifo

//--- rtl/sdram_cmd_decode.sv
/*
 * Command decode, mode word and burst sequencing of a synchronous DRAM.
 * Assumes the controller drives strobes, address and masks on ref_clk;
 * write words go to the array through a FIFO, reads come back in the
 * same cycle as the column is presented.
 */
`timescale 1ns/1ps
`include "sdram_mode_regs.svh"
module sdram_cmd_decode (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [12:0] addr,
    input wire logic [7:0] byte_mask,
    input wire logic [63:0] dq_in,
    input wire logic module_small,
    input wire logic [63:0] arr_rd_data,
    input wire logic arr_wr_ready,
    output logic [63:0] dq_out,
    output logic [7:0] dq_oe,
    output logic arr_rd_en,
    output logic [8:0] arr_rd_col,
    output logic [1:0] arr_rd_bank,
    output logic arr_wr_valid,
    output logic [1:0] arr_wr_bank,
    output logic [8:0] arr_wr_col,
    output logic [7:0] arr_wr_be,
    output logic [63:0] arr_wr_data,
    output logic [11:0] mode_word,
    output logic [3:0] bank_open,
    output logic [3:0] precharge_banks,
    output logic auto_refresh,
    output logic self_refresh,
    output logic [12:0] refresh_row,
    output logic wr_overrun
);
    typedef struct packed {
        sdram_mode_pkg::burst_t burst;
        logic [8:0] start;
        logic [8:0] count;
        logic [8:0] len_mask;
        logic inter;
        logic ap;
        logic [1:0] bank;
        logic [11:0] mode;
        logic [3:0] open;
        logic [3:0] pre;
        logic aref;
        logic sref;
        logic [12:0] row;
        logic rd_en;
        logic rd_en_d1;
        logic [8:0] rd_col;
        logic [1:0] rd_bank;
        logic [7:0] mask_d1;
        logic word_oe;
        logic [7:0] oe;
        logic [63:0] dout;
        logic [63:0] data_d1;
        logic overrun;
        logic small_s1;
        logic small_s2;
    } dec_state_t;

    dec_state_t st_reg;
    dec_state_t st_next;
    sdram_mode_pkg::cmd_t cmd;
    logic [1:0] bank_w;
    logic [8:0] page_mask;
    logic [8:0] start_col;
    logic [2:0] bl_code;
    logic [2:0] rl_code;
    logic rd_acc;
    logic wr_acc;
    logic term_acc;
    logic push_valid;
    logic push_ready;
    logic [1:0] push_bank;
    logic [8:0] push_col;
    logic [8:0] cur_col;
    logic [8:0] lm;

    // column of word k inside the block picked by mask
    function automatic logic [8:0] col_of(input logic [8:0] s,
        input logic [8:0] k, input logic [8:0] m, input logic il);
        logic [8:0] off;
        off = il ? (s ^ k) : (s + k);
        col_of = (s & ~m) | (off & m);
    endfunction : col_of

    // block mask from the burst length code
    function automatic logic [8:0] len_of(input logic [2:0] code,
        input logic [8:0] page);
        case (code)
            `BL_TWO: len_of = 9'h001;
            `BL_FOUR: len_of = 9'h003;
            `BL_EIGHT: len_of = 9'h007;
            `BL_PAGE: len_of = page;
            default: len_of = 9'h000;
        endcase
    endfunction : len_of

    // strobe decode; chip select high masks everything
    always_comb begin
        if (cs_n) begin
            cmd = sdram_mode_pkg::cmd_inhibit;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h7: cmd = sdram_mode_pkg::cmd_nop;
                3'h3: cmd = sdram_mode_pkg::cmd_active;
                3'h5: cmd = sdram_mode_pkg::cmd_read;
                3'h4: cmd = sdram_mode_pkg::cmd_write;
                3'h6: cmd = sdram_mode_pkg::cmd_term;
                3'h2: cmd = sdram_mode_pkg::cmd_precharge;
                3'h1: cmd = sdram_mode_pkg::cmd_refresh;
                default: cmd = sdram_mode_pkg::cmd_load_mode;
            endcase
        end
    end

    // helper terms shared by decode and checks
    assign bank_w = {bank_select_high, bank_select_low};
    assign page_mask = st_reg.small_s2 ? `PAGE_MASK_SMALL
                                       : `PAGE_MASK_LARGE;
    assign start_col = addr[8:0] & page_mask;
    assign bl_code = st_reg.mode[`MODE_BL_MSB:`MODE_BL_LSB];
    assign rl_code = st_reg.mode[`MODE_RL_MSB:`MODE_RL_LSB];
    assign rd_acc = cke && !st_reg.sref &&
                    (cmd == sdram_mode_pkg::cmd_read);
    assign wr_acc = cke && !st_reg.sref &&
                    (cmd == sdram_mode_pkg::cmd_write);
    assign term_acc = cke && !st_reg.sref &&
                      (cmd == sdram_mode_pkg::cmd_term);

    // next state: pipelines, burst sequencing, then new commands
    always_comb begin
        st_next = st_reg;
        st_next.small_s1 = module_small;
        st_next.small_s2 = st_reg.small_s1;
        st_next.pre = 4'h0;
        st_next.aref = 1'b0;
        st_next.rd_en = 1'b0;
        st_next.rd_en_d1 = st_reg.rd_en;
        st_next.mask_d1 = byte_mask;
        st_next.data_d1 = arr_rd_data;
        push_valid = 1'b0;
        push_col = st_reg.start;
        push_bank = st_reg.bank;
        lm = 9'h000;
        cur_col = col_of(st_reg.start, st_reg.count, st_reg.len_mask,
                         st_reg.inter);
        // read output: latency two or three, reserved codes never drive
        case (rl_code)
            `RL_TWO: begin
                st_next.word_oe = st_reg.rd_en;
                st_next.dout = arr_rd_data;
            end
            `RL_THREE: begin
                st_next.word_oe = st_reg.rd_en_d1;
                st_next.dout = st_reg.data_d1;
            end
            default: begin
                st_next.word_oe = 1'b0;
                st_next.dout = st_reg.dout;
            end
        endcase
        st_next.oe = {8{st_next.word_oe}} & ~st_reg.mask_d1;
        // running burst: one column a cycle, writes wait for room
        case (st_reg.burst)
            sdram_mode_pkg::burst_read: begin
                st_next.rd_en = 1'b1;
                st_next.rd_col = cur_col;
                st_next.rd_bank = st_reg.bank;
                st_next.count = st_reg.count + 9'h001;
                if (st_reg.count == st_reg.len_mask) begin
                    st_next.burst = sdram_mode_pkg::burst_idle;
                    st_next.pre[st_reg.bank] = st_reg.ap;
                end
            end
            sdram_mode_pkg::burst_write: begin
                push_valid = 1'b1;
                push_col = cur_col;
                if (push_ready) begin
                    st_next.count = st_reg.count + 9'h001;
                    if (st_reg.count == st_reg.len_mask) begin
                        st_next.burst = sdram_mode_pkg::burst_idle;
                        st_next.pre[st_reg.bank] = st_reg.ap;
                    end
                end
            end
            default: begin
            end
        endcase
        // new reads, writes and burst terminates override a running burst
        if (st_reg.sref) begin
            st_next.sref = !cke;
        end else if (cke) begin
            case (cmd)
                sdram_mode_pkg::cmd_active: begin
                    st_next.open[bank_w] = 1'b1;
                end
                sdram_mode_pkg::cmd_read,
                sdram_mode_pkg::cmd_write: begin
                    lm = len_of(bl_code, page_mask);
                    if ((cmd == sdram_mode_pkg::cmd_write) &&
                        st_reg.mode[`MODE_WB_SINGLE_BIT]) begin
                        lm = 9'h000;
                    end
                    st_next.start = start_col;
                    st_next.bank = bank_w;
                    st_next.len_mask = lm;
                    st_next.count = 9'h001;
                    // full page only runs sequential
                    st_next.inter = st_reg.mode[`MODE_ORDER_BIT] &&
                                    (bl_code != `BL_PAGE);
                    st_next.ap = addr[`PRECHARGE_SEL_BIT];
                    st_next.burst = (cmd == sdram_mode_pkg::cmd_read) ?
                        sdram_mode_pkg::burst_read :
                        sdram_mode_pkg::burst_write;
                    if (cmd == sdram_mode_pkg::cmd_read) begin
                        st_next.rd_en = 1'b1;
                        st_next.rd_col = start_col;
                        st_next.rd_bank = bank_w;
                    end else begin
                        push_valid = 1'b1;
                        push_col = start_col;
                        push_bank = bank_w;
                        if (!push_ready) begin
                            st_next.count = 9'h000;
                        end
                    end
                    if ((lm == 9'h000) && st_next.count != 9'h000) begin
                        st_next.burst = sdram_mode_pkg::burst_idle;
                        st_next.pre[bank_w] = addr[`PRECHARGE_SEL_BIT];
                    end
                end
                sdram_mode_pkg::cmd_term: begin
                    st_next.burst = sdram_mode_pkg::burst_idle;
                end
                sdram_mode_pkg::cmd_precharge: begin
                    if (addr[`PRECHARGE_SEL_BIT]) begin
                        st_next.pre = 4'hf;
                    end else begin
                        st_next.pre[bank_w] = 1'b1;
                    end
                end
                sdram_mode_pkg::cmd_refresh: begin
                    st_next.aref = 1'b1;
                    st_next.row = st_reg.row + 13'h0001;
                end
                sdram_mode_pkg::cmd_load_mode: begin
                    st_next.mode = addr[`MODE_WORD_MSB:0];
                end
                default: begin
                end
            endcase
        end else if (cmd == sdram_mode_pkg::cmd_refresh) begin
            st_next.sref = 1'b1;
            st_next.row = st_reg.row + 13'h0001;
        end
        st_next.open = st_next.open & ~st_next.pre;
        if (push_valid && !push_ready) begin
            st_next.overrun = 1'b1;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // write words with their byte enables, mask applied at once
    data_fifo #(.WIDTH(83), .DEPTH(16)) u_wr_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_valid(push_valid),
        .in_data({push_bank, push_col, ~byte_mask, dq_in}),
        .in_ready(push_ready),
        .out_valid(arr_wr_valid),
        .out_data({arr_wr_bank, arr_wr_col, arr_wr_be, arr_wr_data}),
        .out_ready(arr_wr_ready)
    );

    // outputs straight from the state register
    assign dq_out = st_reg.dout;
    assign dq_oe = st_reg.oe;
    assign arr_rd_en = st_reg.rd_en;
    assign arr_rd_col = st_reg.rd_col;
    assign arr_rd_bank = st_reg.rd_bank;
    assign mode_word = st_reg.mode;
    assign bank_open = st_reg.open;
    assign precharge_banks = st_reg.pre;
    assign auto_refresh = st_reg.aref;
    assign self_refresh = st_reg.sref;
    assign refresh_row = st_reg.row;
    assign wr_overrun = st_reg.overrun;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_quiet;
        !(rd_acc || wr_acc || term_acc);
    endsequence
    sequence s_rd_four_seq;
        rd_acc && (bl_code == `BL_FOUR) && !st_reg.mode[`MODE_ORDER_BIT];
    endsequence
    sequence s_rd_eight_il;
        rd_acc && (bl_code == `BL_EIGHT) && st_reg.mode[`MODE_ORDER_BIT];
    endsequence

    a_seq_four_wrap: assert property (
        s_rd_four_seq ##1 s_quiet |-> arr_rd_col == $past(start_col)
        ##1 arr_rd_col == (($past(start_col, 2) & 9'h1fc) |
            9'(2'($past(start_col[1:0], 2) + 2'h1))))
        else $error("sequential burst of four misordered");
    a_interleave_eight: assert property (
        s_rd_eight_il ##1 s_quiet ##1 s_quiet |->
        arr_rd_col == ($past(start_col, 2) ^ 9'h001))
        else $error("interleaved burst of eight misordered");
    a_latency_two: assert property (
        rd_acc && (rl_code == `RL_TWO) |-> ##2 st_reg.word_oe)
        else $error("latency two first word not driven");
    a_latency_three: assert property (
        rd_acc && (rl_code == `RL_THREE) |-> ##3 st_reg.word_oe)
        else $error("latency three first word not driven");
    a_rl_reserved: assert property (
        (rl_code != `RL_TWO) && (rl_code != `RL_THREE) &&
        $stable(rl_code) |=> dq_oe == 8'h00)
        else $error("reserved latency drove data");
    a_bl_one: assert property (
        rd_acc && (bl_code == `BL_ONE) ##1 s_quiet |=> !arr_rd_en)
        else $error("burst of one ran past one column");
    a_read_mask: assert property (
        st_reg.word_oe |-> dq_oe == ~$past(byte_mask, 2))
        else $error("read byte mask delay wrong");
    a_pre_all: assert property (
        cke && !st_reg.sref && (cmd == sdram_mode_pkg::cmd_precharge) &&
        addr[`PRECHARGE_SEL_BIT] |=> precharge_banks == 4'hf)
        else $error("precharge all missed a bank");
    a_mode_load: assert property (
        cke && !st_reg.sref && (cmd == sdram_mode_pkg::cmd_load_mode)
        |=> mode_word == $past(addr[11:0]))
        else $error("mode word not loaded");
    a_self_refresh: assert property (
        !cke && !st_reg.sref && (cmd == sdram_mode_pkg::cmd_refresh)
        |=> self_refresh && !auto_refresh)
        else $error("self refresh not entered");
    a_inhibit_quiet: assert property (
        cs_n && !st_reg.sref && (st_reg.burst ==
        sdram_mode_pkg::burst_idle) |=> $stable(mode_word) && !auto_refresh)
        else $error("deselected command took effect");
    a_single_write: assert property (
        wr_acc && st_reg.mode[`MODE_WB_SINGLE_BIT] && push_ready
        |=> st_reg.burst == sdram_mode_pkg::burst_idle)
        else $error("single write ran a burst");

endmodule : sdram_cmd_decode

//--- tb/sdram_array_model.sv
/*
 * Array-side stand-in: drives a column-coded word while each read column
 * is shown and accepts FIFO words with random stalls.
 * Assumes the decoder's ref_clk; stall freezes acceptance.
 */
`timescale 1ns/1ps
module sdram_array_model (
    input wire logic ref_clk,
    input wire logic stall,
    input wire logic arr_rd_en,
    input wire logic [1:0] arr_rd_bank,
    input wire logic [8:0] arr_rd_col,
    output logic [63:0] arr_rd_data,
    output logic arr_wr_ready
);
    logic [63:0] held;
    initial held = 64'h0;
    // word for the column shown now; an idle bus turns the last value over
    always_comb begin
        if (arr_rd_en) begin
            arr_rd_data = {8'ha5, 45'h0, arr_rd_bank, arr_rd_col};
        end else begin
            arr_rd_data = ~held;
        end
    end
    // remember the bus, and accept writes at random unless stalled
    always @(posedge ref_clk) begin
        held <= arr_rd_data;
        arr_wr_ready <= !stall && ($urandom % 4 != 0);
    end
endmodule : sdram_array_model

//--- tb/sdram_mode_and_command_decode_bench.sv
/*
 * Self-checking bench for the command decoder: reads, writes, precharge,
 * refresh and FIFO overrun. Assumes the array model in its own file.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module sdram_mode_and_command_decode_bench;
    logic ref_clk, srst, cke, cs_n, ras_n, cas_n, we_n, stall, chk_wr;
    logic bank_select_low, bank_select_high, module_small, arr_rd_en;
    logic arr_wr_ready, arr_wr_valid, auto_refresh, self_refresh, wr_overrun;
    logic [12:0] addr, refresh_row, r0;
    logic [7:0] byte_mask, dq_oe, arr_wr_be;
    logic [63:0] dq_in, arr_rd_data, dq_out, arr_wr_data;
    logic [8:0] arr_rd_col, arr_wr_col;
    logic [1:0] arr_rd_bank, arr_wr_bank;
    logic [11:0] mode_word;
    logic [3:0] bank_open, precharge_banks;
    logic [71:0] rq[$], re;
    logic [82:0] wq[$], we;
    int n_errors = 0, num_checks = 0, cyc = 0;

    sdram_cmd_decode dut (.ref_clk, .srst, .cke, .cs_n, .ras_n, .cas_n,
        .we_n, .bank_select_low, .bank_select_high, .addr, .byte_mask,
        .dq_in, .module_small, .arr_rd_data, .arr_wr_ready, .dq_out, .dq_oe,
        .arr_rd_en, .arr_rd_col, .arr_rd_bank, .arr_wr_valid, .arr_wr_bank,
        .arr_wr_col, .arr_wr_be, .arr_wr_data, .mode_word, .bank_open,
        .precharge_banks, .auto_refresh, .self_refresh, .refresh_row,
        .wr_overrun);
    sdram_array_model arr (.ref_clk, .stall, .arr_rd_en, .arr_rd_bank,
        .arr_rd_col, .arr_rd_data, .arr_wr_ready);

    // clock of 10 ns
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // column of beat k: wrap inside the aligned block
    function automatic logic [8:0] colk(int bl, bit il, logic [8:0] s, int k,
            logic [8:0] pm);
        logic [8:0] m;
        m = (bl == 7) ? pm : 9'((1 << bl) - 1);
        if (il) return (s & ~m) | ((s & m) ^ k[8:0]);
        return (s & ~m) | ((s + k[8:0]) & m);
    endfunction : colk

    // a no-op edge, one command edge, then no-op; pattern is {cs,ras,cas,we}
    task automatic cmd(logic [3:0] p, logic [12:0] a, logic [1:0] b);
        @(negedge ref_clk);
        {cs_n, ras_n, cas_n, we_n} = p;
        addr = a;
        {bank_select_high, bank_select_low} = b;
        @(negedge ref_clk);
        {cs_n, ras_n, cas_n, we_n} = 4'b0111;
    endtask : cmd

    task automatic rd(int bl, bit il, logic [2:0] rl, logic [8:0] s,
            logic [7:0] m);
        int n;
        logic [8:0] pm;
        pm = module_small ? 9'h0ff : 9'h1ff;
        n = (bl == 7) ? int'(pm) + 1 : 1 << bl;
        cmd(4'b0010, 13'h0400, 2'd0);
        cmd(4'b0000, {6'h0, rl, il, bl[2:0]}, 2'd0);
        `CHK(mode_word, {5'h0, rl, il, bl[2:0]})
        cmd(4'b0011, 13'h0, 2'd3);
        byte_mask = m;
        repeat (2) @(negedge ref_clk);
        for (int k = 0; k < n; k++) begin
            if (rl == 3'h2 || rl == 3'h3) begin
                rq.push_back({~m, 8'ha5, 45'h0, 2'd3,
                    colk(bl, il, s & pm, k, pm)});
            end
        end
        cmd(4'b0101, {4'h0, s}, 2'd3);
        repeat (n + 6) @(negedge ref_clk);
        byte_mask = 8'h00;
        $display("read done bl %0d rl %0d", bl, rl);
    endtask : rd

    task automatic wr(int bl, bit one, logic [8:0] s);
        cmd(4'b0010, 13'h0400, 2'd0);
        cmd(4'b0000, {3'h0, one, 2'h0, 3'h2, 1'b0, bl[2:0]}, 2'd0);
        for (int k = 0; k < (1 << bl); k++) begin
            dq_in = {$urandom, $urandom};
            byte_mask = 8'($urandom);
            if (!one || k == 0) begin
                wq.push_back({2'd1, colk(bl, 0, s, k, 9'h1ff), ~byte_mask,
                    dq_in});
            end
            if (k == 0) cmd(4'b0100, {4'h0, s}, 2'd1);
            else @(negedge ref_clk);
        end
        repeat (30) @(negedge ref_clk);
        $display("write done bl %0d single %0d", bl, one);
    endtask : wr

    // watcher: each read word, and each drained write while chk_wr is set, takes the oldest note
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
        if (!srst && dq_oe !== 8'h00) begin
            re = rq.size() ? rq.pop_front() : 72'h0;
            `CHK(dq_oe, re[71:64])
            if (re[71:64] == 8'hff) `CHK(dq_out, re[63:0])
        end
        if (!srst && chk_wr && arr_wr_valid && arr_wr_ready) begin
            we = wq.size() ? wq.pop_front() : 83'h0;
            `CHK({arr_wr_bank, arr_wr_col, arr_wr_be, arr_wr_data}, we)
        end
    end

    // main sequence, all inputs changed on the falling edge
    initial begin
        {srst, cke, cs_n, ras_n, cas_n, we_n, stall, chk_wr} = 8'hfd;
        {bank_select_low, bank_select_high, module_small} = 3'h0;
        {addr, byte_mask, dq_in} = 85'h0;
        void'($urandom(32'h46fe2e0b));
        repeat (12) @(negedge ref_clk);
        srst = 1'b0;
        rd(2, 0, 3'h2, 9'h001, 8'h00);
        rd(3, 1, 3'h3, 9'h0f5, 8'h00);
        rd(3, 0, 3'h2, 9'h00b, 8'h00);
        rd(1, 1, 3'h3, 9'($urandom), 8'h00);
        rd(0, 1, 3'h2, 9'h1a3, 8'h00);
        rd(7, 0, 3'h3, 9'h1fe, 8'h00);
        rd(2, 0, 3'h2, 9'h004, 8'h0f);
        rd(2, 0, 3'h4, 9'h000, 8'h00);
        wr(3, 0, 9'h0fd);
        wr(2, 1, 9'h002);
        cmd(4'b1000, 13'h0fff, 2'd0);
        `CHK(mode_word, 12'h222)
        cmd(4'b0011, 13'h0000, 2'd2);
        cmd(4'b0011, 13'h0000, 2'd1);
        cmd(4'b0010, 13'h0000, 2'd2);
        `CHK(precharge_banks, 4'h4)
        `CHK(bank_open, 4'h2)
        cmd(4'b0010, 13'h0400, 2'd1);
        `CHK(precharge_banks, 4'hf)
        `CHK(bank_open, 4'h0)
        r0 = refresh_row;
        cmd(4'b0001, 13'h0, 2'd0);
        `CHK({auto_refresh, refresh_row}, {1'b1, r0 + 13'h1})
        cke = 1'b0;
        cmd(4'b0001, 13'h0, 2'd0);
        `CHK(self_refresh, 1'b1)
        cke = 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK(self_refresh, 1'b0)
        $display("command checks done");
        module_small = 1'b1;
        rd(7, 0, 3'h2, 9'h1f0, 8'h00);
        {chk_wr, stall} = 2'b01;
        cmd(4'b0000, 13'h0027, 2'd0);
        cmd(4'b0100, 13'h0, 2'd0);
        repeat (24) @(negedge ref_clk);
        cmd(4'b0110, 13'h0, 2'd0);
        `CHK(wr_overrun, 1'b1)
        stall = 1'b0;
        repeat (60) @(negedge ref_clk);
        `CHK(arr_wr_valid, 1'b0)
        srst = 1'b1;
        @(negedge ref_clk);
        srst = 1'b0;
        `CHK({wr_overrun, mode_word}, 13'h0)
        `CHK(rq.size() + wq.size(), 0)
        $display("fifo fill done");
        end_sim();
    end
endmodule : sdram_mode_and_command_decode_bench
